// ---- iss_pkg.sv ----
/*
 Constants and types shared by the impedance sweep sequencer.
 Assumes byte-wide register access at the documented addresses.
*/
package iss_pkg;
  // Byte addresses of the register file
  localparam logic [7:0] ISS_A_CTRL_HI   = 8'h80;
  localparam logic [7:0] ISS_A_CTRL_LO   = 8'h81;
  localparam logic [7:0] ISS_A_START_HI  = 8'h82;
  localparam logic [7:0] ISS_A_START_MID = 8'h83;
  localparam logic [7:0] ISS_A_START_LO  = 8'h84;
  localparam logic [7:0] ISS_A_STEP_HI   = 8'h85;
  localparam logic [7:0] ISS_A_STEP_MID  = 8'h86;
  localparam logic [7:0] ISS_A_STEP_LO   = 8'h87;
  localparam logic [7:0] ISS_A_COUNT_HI  = 8'h88;
  localparam logic [7:0] ISS_A_COUNT_LO  = 8'h89;
  localparam logic [7:0] ISS_A_SETTLE_HI = 8'h8A;
  localparam logic [7:0] ISS_A_SETTLE_LO = 8'h8B;
  localparam logic [7:0] ISS_A_STATUS    = 8'h8F;

  localparam logic [15:0] ISS_CTRL_RESET = 16'hA000;

  // Command codes in the top nibble of the control word
  localparam logic [3:0] ISS_CMD_NOP    = 4'h0;
  localparam logic [3:0] ISS_CMD_INIT   = 4'h1;
  localparam logic [3:0] ISS_CMD_SWEEP  = 4'h2;
  localparam logic [3:0] ISS_CMD_INCR   = 4'h3;
  localparam logic [3:0] ISS_CMD_REPEAT = 4'h4;
  localparam logic [3:0] ISS_CMD_PDN    = 4'hA;
  localparam logic [3:0] ISS_CMD_STBY   = 4'hB;

  // Field positions
  localparam int ISS_CMD_MSB   = 15;
  localparam int ISS_CMD_LSB   = 12;
  localparam int ISS_RANGE_MSB = 10;
  localparam int ISS_RANGE_LSB = 9;
  localparam int ISS_GAIN_BIT  = 8;
  localparam int ISS_RESET_BIT = 4;
  localparam int ISS_STS_VALID = 1;
  localparam int ISS_STS_SWEPT = 2;
  localparam int ISS_MULT_MSB  = 10;
  localparam int ISS_MULT_LSB  = 9;
  localparam int ISS_NUM_MSB   = 8;

  localparam int ISS_FREQ_W = 24;
  localparam int ISS_PTS_W  = 9;
  localparam int ISS_CNT_W  = 11;

  localparam logic [1:0] ISS_MULT_X2 = 2'b01;
  localparam logic [1:0] ISS_MULT_X4 = 2'b11;

  typedef enum logic [2:0] {
    ISS_ST_OFF    = 3'b000,
    ISS_ST_STBY   = 3'b001,
    ISS_ST_HOLD   = 3'b011,
    ISS_ST_SETTLE = 3'b010,
    ISS_ST_MEAS   = 3'b110,
    ISS_ST_POINT  = 3'b111
  } iss_state_t;
endpackage

// ---- iss_settle_if.sv ----
/*
 Link between the sequencer and its settling timer.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface iss_settle_if;
  import iss_pkg::*;
  logic                 start;
  logic                 abort;
  logic                 tick;
  logic [ISS_PTS_W-1:0] cycles;
  logic [1:0]           mult;
  logic                 done;
  modport ctrl  (output start, abort, tick, cycles, mult, input done);
  modport timer (input start, abort, tick, cycles, mult, output done);
endinterface

// ---- iss_settle_timer.sv ----
/*
 Settling timer: counts synthesizer output cycles before a conversion.
 Assumes tick is a one-cycle pulse per output cycle, same clock.
*/
`timescale 1ns/100ps
module iss_settle_timer (
  // Clock and reset
  input logic           clk_sys,
  input logic           arst_n,
  // Sequencer side
  iss_settle_if.timer   sif
);
  import iss_pkg::*;

  typedef struct packed {
    logic                 busy;
    logic [ISS_CNT_W-1:0] cnt;
    logic                 done;
  } iss_tmr_t;

  iss_tmr_t r_reg;
  iss_tmr_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (sif.abort) begin
      r_next.busy = 1'b0;
    end else if (sif.start) begin
      r_next.busy = 1'b1;
      case (sif.mult) // [RL21]
        ISS_MULT_X2: r_next.cnt = {1'b0, sif.cycles, 1'b0};
        ISS_MULT_X4: r_next.cnt = {sif.cycles, 2'b00};
        default:     r_next.cnt = {2'b00, sif.cycles};
      endcase
    end else if (r_reg.busy) begin
      if (r_reg.cnt == '0) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else if (sif.tick) begin
        r_next.cnt = r_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.done = r_reg.done;

  a_settle_scale: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (sif.start && !sif.abort && sif.mult == ISS_MULT_X4) |=> // [RL21]
    r_reg.cnt == {$past(sif.cycles), 2'b00})
    else $error("settle count not scaled by four");
endmodule

// ---- iss_impedance_sweep_sequencer.sv ----
/*
 Control-word decoder and frequency sweep sequencer.
 Assumes the serial bus slave delivers byte reads and writes as
 one-cycle strobes on clk_sys, and that the synthesizer tick and the
 converter done pulse come from logic on the same clock.
// How it works
// [RL1] Top nibble decoded; unknown codes do nothing
// [RL2] Initialize holds start frequency, no measurement
// [RL3] Host waits its own settling, then sweeps
// [RL4] Sweep waits settling cycles, then triggers converter
// [RL5] Increment steps frequency, settles, converts again
// [RL6] Repeat remeasures same point, frequency unchanged
// [RL7] Power-up: power-down code, pins grounded
// [RL8] Standby powers up with pins grounded
// [RL9] Reset aborts sweep, keeps sweep parameters
// [RL10] Range field selects excitation amplitude
// [RL11] Gain bit selects amplifier gain five/one
// [RL12] Start code 24 bits, high byte first
// [RL13] Host computes codes from clock ratio
// [RL14] Increment code 24 bits, added per step
// [RL15] Frequency registers untouched by any reset
// [RL16] Point count nine bits, upper bits ignored
// [RL17] Point count untouched by any reset
// [RL18] Never step beyond programmed increment count
// [RL19] Sweep-complete set at end, reset clears
// [RL20] Valid flag set per point, commands clear
// [RL21] Settling count scaled by one, two, four
// [RL22] Four amplitudes, default code the largest
// [RL23] Command acts on high control byte write
*/
`timescale 1ns/100ps
module iss_impedance_sweep_sequencer (
  // Clock and reset
  input  logic                           clk_sys,
  input  logic                           arst_n,
  // Byte register port
  input  logic [7:0]                     reg_addr,
  input  logic [7:0]                     reg_wdata,
  input  logic                           reg_wr,
  input  logic                           reg_rd,
  output logic [7:0]                     reg_rdata,
  // Frequency synthesizer and converter
  input  logic                           synth_cycle_tick,
  input  logic                           meas_done,
  output logic                           synth_enable,
  output logic [iss_pkg::ISS_FREQ_W-1:0] synth_freq_word,
  output logic                           meas_trigger,
  // Analog front end
  output logic                           excitation_output_gnd,
  output logic                           response_input_gnd,
  output logic [1:0]                     excitation_range,
  output logic                           response_amplifier_gain_x1,
  output logic                           analog_powered
);
  import iss_pkg::*;

  typedef struct packed {
    iss_state_t            st;
    logic [15:0]           ctrl;
    logic [ISS_FREQ_W-1:0] start_f;
    logic [ISS_FREQ_W-1:0] step_f;
    logic [ISS_FREQ_W-1:0] freq;
    logic [15:0]           npts;
    logic [15:0]           settle;
    logic [ISS_PTS_W-1:0]  idx;
    logic                  valid;
    logic                  swept;
    logic                  trig;
    logic                  synth_en;
    logic                  gnd;
    logic                  powered;
    logic [7:0]            rdata;
  } iss_seq_t;

  iss_seq_t r_reg;
  iss_seq_t r_next;

  iss_settle_if sif ();

  logic                 wr_hi;
  logic                 wr_lo;
  logic [15:0]          wr_word;
  logic [3:0]           cmd;
  logic                 rst_cmd;
  logic                 meas_set;
  logic                 last_pt;
  logic                 can_step;
  logic [ISS_PTS_W-1:0] npts9;
  logic                 tmr_start;
  logic                 tmr_abort;
  logic [7:0]           status;

  assign wr_hi    = reg_wr && (reg_addr == ISS_A_CTRL_HI);
  assign wr_lo    = reg_wr && (reg_addr == ISS_A_CTRL_LO);
  assign wr_word  = {reg_wdata, r_reg.ctrl[7:0]};
  // Only a high-byte write carries a command code; the reset bit comes from a low-byte write
  assign cmd      = wr_hi ? wr_word[ISS_CMD_MSB:ISS_CMD_LSB]
                          : ISS_CMD_NOP; // [RL23]
  assign rst_cmd  = wr_lo && reg_wdata[ISS_RESET_BIT];
  assign npts9    = r_reg.npts[ISS_NUM_MSB:0]; // [RL16]
  assign can_step = r_reg.idx < npts9; // [RL18]
  assign last_pt  = r_reg.idx >= npts9;
  assign meas_set = (r_reg.st == ISS_ST_MEAS) && meas_done;

  assign sif.start  = tmr_start;
  assign sif.abort  = tmr_abort;
  assign sif.tick   = synth_cycle_tick;
  assign sif.cycles = r_reg.settle[ISS_NUM_MSB:0];
  assign sif.mult   = r_reg.settle[ISS_MULT_MSB:ISS_MULT_LSB];

  iss_settle_timer u_settle (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .sif     (sif)
  );

  always_comb begin
    r_next      = r_reg;
    r_next.trig = 1'b0;
    tmr_start   = 1'b0;
    tmr_abort   = 1'b0;
    status      = '0;

    // Register writes; frequencies high byte first
    if (reg_wr) begin
      case (reg_addr)
        ISS_A_CTRL_HI:   r_next.ctrl[15:8] = reg_wdata;
        // Reset bit acts once and reads back as zero
        ISS_A_CTRL_LO: begin
          r_next.ctrl[7:0] = reg_wdata;
          r_next.ctrl[ISS_RESET_BIT] = 1'b0;
        end
        ISS_A_START_HI:  r_next.start_f[23:16] = reg_wdata; // [RL12]
        ISS_A_START_MID: r_next.start_f[15:8]  = reg_wdata; // [RL12]
        ISS_A_START_LO:  r_next.start_f[7:0]   = reg_wdata; // [RL12]
        ISS_A_STEP_HI:   r_next.step_f[23:16]  = reg_wdata; // [RL14]
        ISS_A_STEP_MID:  r_next.step_f[15:8]   = reg_wdata; // [RL14]
        ISS_A_STEP_LO:   r_next.step_f[7:0]    = reg_wdata; // [RL14]
        ISS_A_COUNT_HI:  r_next.npts[15:8]     = reg_wdata;
        ISS_A_COUNT_LO:  r_next.npts[7:0]      = reg_wdata;
        ISS_A_SETTLE_HI: r_next.settle[15:8]   = reg_wdata;
        ISS_A_SETTLE_LO: r_next.settle[7:0]    = reg_wdata;
        default: ;
      endcase
    end

    // Measurement flow
    case (r_reg.st)
      ISS_ST_SETTLE: begin
        if (sif.done) begin
          r_next.trig = 1'b1; // [RL4]
          r_next.st   = ISS_ST_MEAS;
        end
      end
      ISS_ST_MEAS: begin
        if (meas_done) begin
          r_next.st = ISS_ST_POINT;
        end
      end
      default: ;
    endcase

    // Commands override the flow; a nop leaves it alone
    case (cmd) // [RL1]
      ISS_CMD_INIT: begin
        r_next.freq = r_reg.start_f; // [RL2]
        r_next.idx  = '0;
        r_next.st   = ISS_ST_HOLD;
        tmr_abort   = 1'b1;
      end
      ISS_CMD_SWEEP: begin
        r_next.valid = 1'b0; // [RL20]
        r_next.swept = 1'b0;
        r_next.st    = ISS_ST_SETTLE; // [RL4]
        tmr_start    = 1'b1;
      end
      ISS_CMD_INCR: begin
        // Past the last point the command is ignored
        if (can_step) begin // [RL18]
          r_next.freq  = r_reg.freq + r_reg.step_f; // [RL5] [RL14]
          r_next.idx   = r_reg.idx + 1'b1;
          r_next.valid = 1'b0; // [RL20]
          r_next.st    = ISS_ST_SETTLE;
          tmr_start    = 1'b1;
        end
      end
      ISS_CMD_REPEAT: begin
        r_next.valid = 1'b0; // [RL20]
        r_next.st    = ISS_ST_SETTLE; // [RL6]
        tmr_start    = 1'b1;
      end
      ISS_CMD_PDN: begin
        r_next.st = ISS_ST_OFF;
        tmr_abort = 1'b1;
      end
      ISS_CMD_STBY: begin
        r_next.st = ISS_ST_STBY; // [RL8]
        tmr_abort = 1'b1;
      end
      default: ;
    endcase

    // Sweep registers are left alone here
    if (rst_cmd) begin // [RL9] [RL15] [RL17]
      r_next.st    = ISS_ST_STBY;
      r_next.valid = 1'b0; // [RL20]
      r_next.swept = 1'b0; // [RL19]
      tmr_abort    = 1'b1;
      tmr_start    = 1'b0;
    end

    // Completion is applied last so it is never lost to a clear
    if (meas_set) begin
      r_next.valid = 1'b1; // [RL20]
      if (last_pt) begin
        r_next.swept = 1'b1; // [RL19]
      end
    end

    r_next.gnd      = (r_next.st == ISS_ST_OFF) ||
                      (r_next.st == ISS_ST_STBY); // [RL7] [RL8]
    r_next.powered  = r_next.st != ISS_ST_OFF;
    r_next.synth_en = !r_next.gnd;

    status[ISS_STS_VALID] = r_reg.valid;
    status[ISS_STS_SWEPT] = r_reg.swept;
    if (reg_rd) begin
      case (reg_addr)
        ISS_A_CTRL_HI:   r_next.rdata = r_reg.ctrl[15:8];
        ISS_A_CTRL_LO:   r_next.rdata = r_reg.ctrl[7:0];
        ISS_A_START_HI:  r_next.rdata = r_reg.start_f[23:16];
        ISS_A_START_MID: r_next.rdata = r_reg.start_f[15:8];
        ISS_A_START_LO:  r_next.rdata = r_reg.start_f[7:0];
        ISS_A_STEP_HI:   r_next.rdata = r_reg.step_f[23:16];
        ISS_A_STEP_MID:  r_next.rdata = r_reg.step_f[15:8];
        ISS_A_STEP_LO:   r_next.rdata = r_reg.step_f[7:0];
        ISS_A_COUNT_HI:  r_next.rdata = r_reg.npts[15:8];
        ISS_A_COUNT_LO:  r_next.rdata = r_reg.npts[7:0];
        ISS_A_SETTLE_HI: r_next.rdata = r_reg.settle[15:8];
        ISS_A_SETTLE_LO: r_next.rdata = r_reg.settle[7:0];
        ISS_A_STATUS:    r_next.rdata = status;
        default:         r_next.rdata = 8'h00;
      endcase
    end
  end

  // Sweep parameters carry no reset: they keep what they hold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_reg.st       <= ISS_ST_OFF; // [RL7]
      r_reg.ctrl     <= ISS_CTRL_RESET; // [RL7]
      r_reg.freq     <= '0;
      r_reg.idx      <= '0;
      r_reg.valid    <= 1'b0; // [RL20]
      r_reg.swept    <= 1'b0; // [RL19]
      r_reg.trig     <= 1'b0;
      r_reg.synth_en <= 1'b0;
      r_reg.gnd      <= 1'b1; // [RL7]
      r_reg.powered  <= 1'b0;
      r_reg.rdata    <= 8'h00;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata                  = r_reg.rdata;
  assign synth_enable               = r_reg.synth_en;
  assign synth_freq_word            = r_reg.freq;
  assign meas_trigger               = r_reg.trig;
  assign excitation_output_gnd      = r_reg.gnd;
  assign response_input_gnd         = r_reg.gnd;
  // Code 00 is the largest swing
  assign excitation_range           =
    r_reg.ctrl[ISS_RANGE_MSB:ISS_RANGE_LSB]; // [RL10] [RL22]
  assign response_amplifier_gain_x1 = r_reg.ctrl[ISS_GAIN_BIT]; // [RL11]
  assign analog_powered             = r_reg.powered;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_nop_keeps_hold: assert property ( // [RL1]
    (cmd == ISS_CMD_NOP && wr_hi &&
     (r_reg.st == ISS_ST_HOLD || r_reg.st == ISS_ST_POINT))
    |=> $stable(r_reg.st))
    else $error("nop changed sweep state");

  a_init_start_freq: assert property ( // [RL2]
    (cmd == ISS_CMD_INIT && !rst_cmd) |=>
    synth_freq_word == $past(r_reg.start_f) && synth_enable)
    else $error("initialize did not load start frequency");

  a_hold_no_trig: assert property ( // [RL2]
    (r_reg.st == ISS_ST_HOLD) |=> !meas_trigger)
    else $error("trigger while holding start frequency");

  a_trig_after_settle: assert property ( // [RL4]
    meas_trigger |-> $past(sif.done) && $past(r_reg.st) == ISS_ST_SETTLE)
    else $error("trigger without settling done");

  a_incr_step: assert property ( // [RL5]
    (cmd == ISS_CMD_INCR && can_step) |=>
    synth_freq_word == $past(r_reg.freq) + $past(r_reg.step_f)
    ##1 r_reg.st == ISS_ST_SETTLE || sif.done || meas_trigger)
    else $error("increment did not step frequency");

  a_repeat_same: assert property ( // [RL6]
    (cmd == ISS_CMD_REPEAT) |=>
    $stable(synth_freq_word) && r_reg.st == ISS_ST_SETTLE)
    else $error("repeat changed frequency");

  a_stby_grounded: assert property ( // [RL8]
    (cmd == ISS_CMD_STBY) |=> excitation_output_gnd &&
    response_input_gnd && analog_powered && !synth_enable)
    else $error("standby pins not grounded");

  a_reset_keeps: assert property ( // [RL9]
    (rst_cmd && !meas_set) |=> $stable(r_reg.start_f) &&
    $stable(r_reg.step_f) && $stable(r_reg.npts) && !r_reg.valid
    && !r_reg.swept && r_reg.st == ISS_ST_STBY)
    else $error("reset command lost parameters or flags");

  a_range_gain: assert property ( // [RL10] [RL11]
    wr_hi |=> excitation_range ==
      $past(reg_wdata[ISS_RANGE_MSB-8:ISS_RANGE_LSB-8]) &&
    response_amplifier_gain_x1 == $past(reg_wdata[ISS_GAIN_BIT-8]))
    else $error("range or gain not applied");

  a_no_overstep: assert property ( // [RL18]
    (cmd == ISS_CMD_INCR && !can_step) |=> $stable(synth_freq_word))
    else $error("stepped past point count");

  a_swept_set: assert property ( // [RL19]
    (meas_set && last_pt) |=> r_reg.swept && r_reg.valid)
    else $error("sweep complete not set");

  a_valid_clear: assert property ( // [RL20]
    ((cmd == ISS_CMD_SWEEP || cmd == ISS_CMD_REPEAT) && !meas_set)
    |=> !r_reg.valid)
    else $error("valid not cleared by command");

  c_point_done: cover property (meas_set);
  c_sweep_done: cover property (meas_set && last_pt);
  c_repeat_run: cover property (cmd == ISS_CMD_REPEAT ##[1:50] meas_trigger);
  c_reset_mid:  cover property (r_reg.st == ISS_ST_SETTLE && rst_cmd);
endmodule

// ---- iss_front_model.sv ----
/*
 Front-end model: synthesizer output ticks and converter completion.
 Assumes the sequencer's clock and reset, one-cycle trigger pulses.
*/
`timescale 1ns/100ps
module iss_front_model #(
  parameter int TICK_DIV = 5,
  parameter int CONV_LAT = 20
) (
  // Clock and reset
  input  logic clk_sys,
  input  logic arst_n,
  // Sequencer side
  input  logic synth_enable,
  input  logic meas_trigger,
  output logic synth_cycle_tick,
  output logic meas_done
);
  int div_cnt;
  int conv_cnt;
  // A stopped synthesizer gives no ticks at all
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 0;
      conv_cnt <= 0;
      synth_cycle_tick <= 1'b0;
      meas_done <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      synth_cycle_tick <= synth_enable && (div_cnt == TICK_DIV - 1);
      meas_done <= (conv_cnt == 1);
      if (meas_trigger) begin
        conv_cnt <= CONV_LAT;
      end else if (conv_cnt > 0) begin
        conv_cnt <= conv_cnt - 1;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
/*
 Self-checking bench for the sweep sequencer, with a reference model.
 Assumes the front-end model and the design package are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  import iss_pkg::*;
  logic                  clk_sys, arst_n, reg_wr, reg_rd;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, rd_q;
  logic                  tick, done, synth_enable, meas_trigger;
  logic                  ex_gnd, in_gnd, gain_x1, powered;
  logic [1:0]            range_q;
  logic [ISS_FREQ_W-1:0] freq_q;
  int                    err_total, cmp_count, cycles, ticks, trigs;
  int                    m_start, m_step, m_cnt, m_idx, m_set;
  int                    fac [4] = '{1, 2, 1, 4};
  logic [7:0]            b [8];

  iss_impedance_sweep_sequencer dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .synth_cycle_tick(tick),
    .meas_done(done), .synth_enable(synth_enable), .synth_freq_word(freq_q),
    .meas_trigger(meas_trigger), .excitation_output_gnd(ex_gnd),
    .response_input_gnd(in_gnd), .excitation_range(range_q),
    .response_amplifier_gain_x1(gain_x1), .analog_powered(powered));
  iss_front_model front_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .synth_enable(synth_enable), .meas_trigger(meas_trigger),
    .synth_cycle_tick(tick), .meas_done(done));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Event counters and a hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (tick) ticks++;
    if (meas_trigger) trigs++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic verify_regs();
    for (int i = 0; i < 8; i++) begin
      rd(ISS_A_START_HI + 8'(i));
      check(rd_q, b[i]);
    end
  endtask
  // One measured point; a negative tick figure skips the settle count
  task automatic point(input int exp_ticks);
    int n;
    // Timer loads on the command edge; count every tick after it
    ticks = 0;
    n = 0;
    while (meas_trigger !== 1'b1 && n < 9000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 9000) err_total++;
    if (exp_ticks >= 0) check(ticks, exp_ticks);
    check(freq_q, 24'(m_start + m_idx * m_step));
    repeat (24) @(posedge clk_sys);
    rd(ISS_A_STATUS);
    check(rd_q, ((m_idx >= m_cnt) ? 6 : 2));
  endtask

  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(61813));
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ISS_A_CTRL_HI);
    check(rd_q, 8'hA0);
    check({ex_gnd, in_gnd, powered, synth_enable, range_q, gain_x1},
          7'b1100000);
    rd(ISS_A_STATUS);
    check(rd_q, 8'h00);
    rd(8'h90);
    check(rd_q, 8'h00);
    $display("Test power-up defaults ended");
    // Host-side code for 30 kHz at a 1 MHz clock
    m_start = int'(64'd30000 * (64'd1 << 27) / 64'd1000000);
    m_step = $urandom_range(16'hFFFF, 1);
    m_cnt = 2;
    b = '{m_start[23:16], m_start[15:8], m_start[7:0], m_step[23:16],
          m_step[15:8], m_step[7:0], 8'h00, 8'(m_cnt)};
    for (int i = 0; i < 8; i++) wr(ISS_A_START_HI + 8'(i), b[i]);
    wr(ISS_A_STATUS, 8'hFF);
    verify_regs();
    wr(ISS_A_CTRL_HI, 8'hB0);
    check({ex_gnd, in_gnd, powered, synth_enable}, 4'b1110);
    $display("Test registers and standby ended");
    for (int m = 0; m < 4; m++) begin
      m_set = $urandom_range(6, 1);
      wr(ISS_A_SETTLE_HI, 8'(m << 1));
      wr(ISS_A_SETTLE_LO, 8'(m_set));
      wr(ISS_A_CTRL_HI, 8'h10);
      m_idx = 0;
      check({ex_gnd, in_gnd, synth_enable}, 3'b001);
      trigs = 0;
      repeat (40) @(posedge clk_sys);
      check(trigs, 0);
      wr(ISS_A_CTRL_HI, 8'h20);
      point(m_set * fac[m]);
    end
    $display("Test settle multipliers ended");
    // Upper count bits must not lengthen the sweep
    wr(ISS_A_COUNT_HI, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      wr(ISS_A_CTRL_HI, 8'h30);
      if (m_idx < m_cnt) begin
        m_idx++;
        point(m_set * 4);
      end else begin
        check(freq_q, 24'(m_start + m_idx * m_step));
        rd(ISS_A_STATUS);
        check(rd_q, 8'h06);
      end
    end
    wr(ISS_A_CTRL_HI, 8'h40);
    rd(ISS_A_STATUS);
    check(rd_q, 8'h04);
    point(-1);
    $display("Test increment and repeat ended");
    for (int c = 0; c < 16; c++) begin
      if (c inside {[1:4], 10, 11}) continue;
      b[0] = {4'(c), 4'($urandom_range(15, 0))};
      wr(ISS_A_CTRL_HI, b[0]);
      check({synth_enable, range_q, gain_x1}, {1'b1, b[0][2:0]});
      check(freq_q, 24'(m_start + m_idx * m_step));
      rd(ISS_A_CTRL_HI);
      check(rd_q, b[0]);
    end
    $display("Test no-operation codes ended");
    wr(ISS_A_CTRL_LO, 8'h10);
    rd(ISS_A_STATUS);
    check(rd_q, 8'h00);
    check({ex_gnd, in_gnd, powered, synth_enable}, 4'b1110);
    rd(ISS_A_CTRL_LO);
    check(rd_q, 8'h00);
    b = '{m_start[23:16], m_start[15:8], m_start[7:0], m_step[23:16],
          m_step[15:8], m_step[7:0], 8'hFE, 8'(m_cnt)};
    verify_regs();
    wr(ISS_A_CTRL_HI, 8'h10);
    m_idx = 0;
    check(freq_q, m_start);
    wr(ISS_A_CTRL_HI, 8'h20);
    point(m_set * 4);
    wr(ISS_A_CTRL_HI, 8'hA0);
    check({ex_gnd, in_gnd, powered, synth_enable}, 4'b1100);
    $display("Test reset command and power-down ended");
    give_verdict();
  end
endmodule
